// ---- pkg/pin_sig_pkg.sv ----
// Purpose: shared constants for the dual-channel serial pin signalling
// Assumes: 40 MHz clk, asynchronous active-low reset nrst
// Notes: control bits arrive as plain ports; the field positions below
//        give where each bit sits in the per-channel control bytes
// Notes on behaviour
// - Strobe bus and modem-control bit 3 set: interrupt pin driven, general output low.
// - Strobe bus and modem-control bit 3 clear: interrupt pin released, general output high.
// - Read/write-line bus: second channel interrupt pin held low.
// - Each channel drives an active-low transmit-ready pin from its transmit buffer state.
// - Each channel drives an active-low receive-ready pin from its receive buffer state.
// - Modem-control bit 6 clear: standard line, transmit high in reset and idle.
// - Modem-control bit 6 set: infrared mode, transmit rests low when idle.
// - Feature-control bit 2 inverts the infrared receive input before decoding.
// - Enhanced-feature bit 7 makes clear-to-send gate transmission, else it is a plain input.
// - Set-ready, carrier and ring inputs are status only and never touch transmit or receive.
// - Terminal-ready and request-to-send are active-low outputs also usable as plain outputs.
// - Bus-select high picks the strobe bus, low picks the read/write-line bus.
`default_nettype none
package pin_sig_pkg;
    // =====================================================
    // control byte field positions
    localparam int MODEM_DTR_BIT = 0;
    localparam int MODEM_RTS_BIT = 1;
    localparam int MODEM_GP_BIT = 3;
    localparam int MODEM_IR_BIT = 6;
    localparam int FEAT_IR_INV_BIT = 2;
    localparam int ENH_AUTO_CTS_BIT = 7;
    localparam int CTRL_W = 8;
    // =====================================================
    // reset values of driven pins
    localparam logic RST_HIGH = 1'h1;
    localparam logic RST_LOW = 1'h0;
    localparam int SYNC_STAGES = 2;
endpackage
`default_nettype wire

// ---- hw/pin_chan.sv ----
// Purpose: one channel of serial pin signalling
// Assumes: async inputs already synchronised by the parent
// Notes: all outputs registered
`default_nettype none
module pin_chan
    import pin_sig_pkg::*;
(
    input wire logic clk, // system clock
    input wire logic nrst, // async reset, active low
    input wire logic strobe_bus, // strobe bus style selected
    input wire logic [pin_sig_pkg::CTRL_W-1:0] modem_control_reg, // mode bits
    input wire logic [pin_sig_pkg::CTRL_W-1:0] feature_control_reg, // ir inv
    input wire logic [pin_sig_pkg::CTRL_W-1:0] enhanced_feature_reg, // flow
    input wire logic irq_req, // channel interrupt pending
    input wire logic tx_bit, // serial bit from transmitter core
    input wire logic tx_busy, // transmitter sending a frame
    input wire logic ir_pulse, // infrared encoder pulse
    input wire logic tx_space, // transmit buffer can take data
    input wire logic rx_avail, // receive buffer holds data
    input wire logic rx_pin_s, // synchronised receive pin
    input wire logic cts_n_s, // synchronised clear-to-send pin
    output logic irq_o, // interrupt pin level
    output logic irq_oe, // interrupt pin enable
    output logic gp_out, // general output port
    output logic tx_ready_n, // transmit ready, active low
    output logic rx_ready_n, // receive ready, active low
    output logic serial_out, // serial transmit pin
    output logic rts_n, // request to send, active low
    output logic dtr_n, // terminal ready, active low
    output logic rx_to_core, // standard receive data
    output logic rx_to_ir, // infrared decoder input
    output logic tx_allow // transmission allowed
);
    import pin_sig_pkg::*;
    typedef struct packed {
        logic irq; logic irq_oe; logic gp; logic txr; logic rxr;
        logic sout; logic rts; logic dtr; logic rxc; logic rxi; logic allow;
    } chan_st_t;
    chan_st_t st_ff;
    chan_st_t nxt_st;
    // =====================================================
    // next-state logic
    always_comb
    begin
        nxt_st = st_ff;
        // open drain on strobe bus is emulated by enable, level is the request
        nxt_st.irq = strobe_bus ? irq_req : RST_LOW;
        nxt_st.irq_oe = strobe_bus ? modem_control_reg[MODEM_GP_BIT]
                                   : RST_LOW;
        nxt_st.gp = ~modem_control_reg[MODEM_GP_BIT];
        nxt_st.txr = ~tx_space;
        nxt_st.rxr = ~rx_avail;
        if (modem_control_reg[MODEM_IR_BIT])
            nxt_st.sout = tx_busy & ir_pulse;
        else
            nxt_st.sout = tx_busy ? tx_bit : RST_HIGH;
        nxt_st.rts = ~modem_control_reg[MODEM_RTS_BIT];
        nxt_st.dtr = ~modem_control_reg[MODEM_DTR_BIT];
        nxt_st.rxc = modem_control_reg[MODEM_IR_BIT] ? RST_HIGH : rx_pin_s;
        nxt_st.rxi = modem_control_reg[MODEM_IR_BIT]
            ? (rx_pin_s ^ feature_control_reg[FEAT_IR_INV_BIT])
            : RST_LOW;
        // set-ready, carrier and ring never reach this gate
        nxt_st.allow = enhanced_feature_reg[ENH_AUTO_CTS_BIT]
            ? ~cts_n_s : RST_HIGH;
    end
    // =====================================================
    // state register
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            st_ff <= '{irq: RST_LOW, irq_oe: RST_LOW, gp: RST_HIGH,
                       txr: RST_HIGH, rxr: RST_HIGH, sout: RST_HIGH,
                       rts: RST_HIGH, dtr: RST_HIGH, rxc: RST_HIGH,
                       rxi: RST_LOW, allow: RST_HIGH};
        else
            st_ff <= nxt_st;
    end
    assign irq_o = st_ff.irq;
    assign irq_oe = st_ff.irq_oe;
    assign gp_out = st_ff.gp;
    assign tx_ready_n = st_ff.txr;
    assign rx_ready_n = st_ff.rxr;
    assign serial_out = st_ff.sout;
    assign rts_n = st_ff.rts;
    assign dtr_n = st_ff.dtr;
    assign rx_to_core = st_ff.rxc;
    assign rx_to_ir = st_ff.rxi;
    assign tx_allow = st_ff.allow;
    // =====================================================
    // checks
    op2_follow_a: assert property (@(posedge clk) disable iff (!nrst)
        1'h1 |=> gp_out == !$past(modem_control_reg[MODEM_GP_BIT]))
        else $error("general output wrong");
    irq_drive_a: assert property (@(posedge clk) disable iff (!nrst)
        strobe_bus && modem_control_reg[MODEM_GP_BIT] |=> irq_oe)
        else $error("interrupt pin not driven");
    irq_release_a: assert property (@(posedge clk) disable iff (!nrst)
        strobe_bus && !modem_control_reg[MODEM_GP_BIT] |=> !irq_oe)
        else $error("interrupt pin not released");
    tx_idle_a: assert property (@(posedge clk) disable iff (!nrst)
        !tx_busy && !modem_control_reg[MODEM_IR_BIT] |=> serial_out)
        else $error("standard idle not high");
    ir_idle_a: assert property (@(posedge clk) disable iff (!nrst)
        !tx_busy && modem_control_reg[MODEM_IR_BIT] |=> !serial_out)
        else $error("infrared idle not low");
    ir_invert_a: assert property (@(posedge clk) disable iff (!nrst)
        modem_control_reg[MODEM_IR_BIT] |=> rx_to_ir ==
            ($past(rx_pin_s) ^ $past(feature_control_reg[FEAT_IR_INV_BIT])))
        else $error("infrared inversion wrong");
    cts_gate_a: assert property (@(posedge clk) disable iff (!nrst)
        enhanced_feature_reg[ENH_AUTO_CTS_BIT] && cts_n_s |=> !tx_allow)
        else $error("clear-to-send not gating");
    txrdy_a: assert property (@(posedge clk) disable iff (!nrst)
        1'h1 |=> tx_ready_n == !$past(tx_space))
        else $error("transmit ready wrong");
    rxrdy_a: assert property (@(posedge clk) disable iff (!nrst)
        1'h1 |=> rx_ready_n == !$past(rx_avail))
        else $error("receive ready wrong");
    modem_out_a: assert property (@(posedge clk) disable iff (!nrst)
        1'h1 |=> rts_n == !$past(modem_control_reg[MODEM_RTS_BIT]) &&
                 dtr_n == !$past(modem_control_reg[MODEM_DTR_BIT]))
        else $error("modem outputs wrong");
endmodule
`default_nettype wire

// ---- hw/dual_uart_pin_signalling.sv ----
// Purpose: two-channel serial pin signalling top
// Assumes: pins asynchronous, control bytes on clk
// Notes: channel B interrupt forced low on read/write-line bus
`default_nettype none
module dual_uart_pin_signalling
    import pin_sig_pkg::*;
(
    input wire logic clk, // 40 MHz clock
    input wire logic nrst, // async reset, active low
    input wire logic bus_sel_pin, // high strobe bus, low rw-line bus
    input wire logic [pin_sig_pkg::CTRL_W-1:0] a_modem_control_reg, // a modem
    input wire logic [pin_sig_pkg::CTRL_W-1:0] a_feature_control_reg, // a feat
    input wire logic [pin_sig_pkg::CTRL_W-1:0] a_enhanced_feature_reg, // a cts
    input wire logic [pin_sig_pkg::CTRL_W-1:0] b_modem_control_reg, // b modem
    input wire logic [pin_sig_pkg::CTRL_W-1:0] b_feature_control_reg, // b feat
    input wire logic [pin_sig_pkg::CTRL_W-1:0] b_enhanced_feature_reg, // b cts
    input wire logic [1:0] irq_req, // interrupt pending per chan
    input wire logic [1:0] tx_bit, // core tx bit per chan
    input wire logic [1:0] tx_busy, // tx frame active per chan
    input wire logic [1:0] ir_pulse, // ir encoder pulse per chan
    input wire logic [1:0] tx_space, // tx buffer room per chan
    input wire logic [1:0] rx_avail, // rx buffer data per chan
    input wire logic chan_a_serial_in, // chan a receive pin
    input wire logic chan_b_serial_in, // chan b receive pin
    input wire logic chan_a_clear_send_n, // chan a clear to send
    input wire logic chan_b_clear_send_n, // chan b clear to send
    output logic chan_a_irq_out, // chan a interrupt level
    output logic chan_a_irq_oe, // chan a interrupt enable
    output logic chan_b_irq_out, // chan b interrupt level
    output logic chan_b_irq_oe, // chan b interrupt enable
    output logic chan_a_gp_out_port, // chan a general output
    output logic chan_b_gp_out_port, // chan b general output
    output logic chan_a_tx_ready_n, // chan a tx ready
    output logic chan_a_rx_ready_n, // chan a rx ready
    output logic chan_b_tx_ready_n, // chan b tx ready
    output logic chan_b_rx_ready_n, // chan b rx ready
    output logic chan_a_serial_out, // chan a transmit pin
    output logic chan_b_serial_out, // chan b transmit pin
    output logic chan_a_request_send_n, // chan a rts
    output logic chan_b_request_send_n, // chan b rts
    output logic chan_a_terminal_ready_n, // chan a dtr
    output logic chan_b_terminal_ready_n, // chan b dtr
    output logic [1:0] rx_to_core, // standard rx data per chan
    output logic [1:0] rx_to_ir, // ir decoder input per chan
    output logic [1:0] tx_allow // transmission allowed per chan
);
    import pin_sig_pkg::*;
    typedef struct packed {
        logic [SYNC_STAGES-1:0] sel;
        logic [SYNC_STAGES-1:0] rx_a; logic [SYNC_STAGES-1:0] rx_b;
        logic [SYNC_STAGES-1:0] cts_a; logic [SYNC_STAGES-1:0] cts_b;
        logic b_oe; // chan b interrupt enable, kept on for the rw-line bus
    } sync_t;
    sync_t sy_ff;
    sync_t nxt_sy;
    logic strobe_bus;
    logic a_irq, a_oe, b_irq;
    // =====================================================
    // two-flop synchronisers, only the second stage [1] is read downstream
    always_comb
    begin
        nxt_sy.sel = {sy_ff.sel[0], bus_sel_pin};
        nxt_sy.rx_a = {sy_ff.rx_a[0], chan_a_serial_in};
        nxt_sy.rx_b = {sy_ff.rx_b[0], chan_b_serial_in};
        nxt_sy.cts_a = {sy_ff.cts_a[0], chan_a_clear_send_n};
        nxt_sy.cts_b = {sy_ff.cts_b[0], chan_b_clear_send_n};
        // a steady low must be driven, a released pin would float
        nxt_sy.b_oe = strobe_bus ? b_modem_control_reg[MODEM_GP_BIT]
                                 : RST_HIGH;
    end
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            // idle-high lines, strobe bus, interrupt pin released
            sy_ff <= '{sel: '1, rx_a: '1, rx_b: '1, cts_a: '1, cts_b: '1,
                       b_oe: RST_LOW};
        else
            sy_ff <= nxt_sy;
    end
    assign strobe_bus = sy_ff.sel[1];
    // =====================================================
    // channels, each on its own bytes only
    pin_chan u_a (.clk(clk), .nrst(nrst), .strobe_bus(strobe_bus),
        .modem_control_reg(a_modem_control_reg),
        .feature_control_reg(a_feature_control_reg),
        .enhanced_feature_reg(a_enhanced_feature_reg), .irq_req(irq_req[0]),
        .tx_bit(tx_bit[0]), .tx_busy(tx_busy[0]), .ir_pulse(ir_pulse[0]),
        .tx_space(tx_space[0]), .rx_avail(rx_avail[0]),
        .rx_pin_s(sy_ff.rx_a[1]), .cts_n_s(sy_ff.cts_a[1]),
        .irq_o(a_irq), .irq_oe(a_oe), .gp_out(chan_a_gp_out_port),
        .tx_ready_n(chan_a_tx_ready_n), .rx_ready_n(chan_a_rx_ready_n),
        .serial_out(chan_a_serial_out), .rts_n(chan_a_request_send_n),
        .dtr_n(chan_a_terminal_ready_n), .rx_to_core(rx_to_core[0]),
        .rx_to_ir(rx_to_ir[0]), .tx_allow(tx_allow[0]));
    pin_chan u_b (.clk(clk), .nrst(nrst), .strobe_bus(strobe_bus),
        .modem_control_reg(b_modem_control_reg),
        .feature_control_reg(b_feature_control_reg),
        .enhanced_feature_reg(b_enhanced_feature_reg), .irq_req(irq_req[1]),
        .tx_bit(tx_bit[1]), .tx_busy(tx_busy[1]), .ir_pulse(ir_pulse[1]),
        .tx_space(tx_space[1]), .rx_avail(rx_avail[1]),
        .rx_pin_s(sy_ff.rx_b[1]), .cts_n_s(sy_ff.cts_b[1]),
        .irq_o(b_irq), .irq_oe(), .gp_out(chan_b_gp_out_port),
        .tx_ready_n(chan_b_tx_ready_n), .rx_ready_n(chan_b_rx_ready_n),
        .serial_out(chan_b_serial_out), .rts_n(chan_b_request_send_n),
        .dtr_n(chan_b_terminal_ready_n), .rx_to_core(rx_to_core[1]),
        .rx_to_ir(rx_to_ir[1]), .tx_allow(tx_allow[1]));
    // =====================================================
    // interrupt pins; on the rw-line bus chan b is driven low constantly
    assign chan_a_irq_out = a_irq;
    assign chan_a_irq_oe = a_oe;
    assign chan_b_irq_out = b_irq;
    assign chan_b_irq_oe = sy_ff.b_oe;
    rwbus_b_low_a: assert property (@(posedge clk) disable iff (!nrst)
        !strobe_bus |=> !chan_b_irq_out && chan_b_irq_oe)
        else $error("chan b interrupt not driven low");
endmodule
`default_nettype wire

// ---- bench/line_src.sv ----
// Purpose: far serial source model driving one receive pin
// Assumes: bench steers it off the falling clock edge
// Notes: idle level follows the line mode of the channel
`default_nettype none
module line_src (
    input wire logic ir_mode, // infrared line in use
    input wire logic active, // a bit is on the line
    input wire logic bit_val, // value of that bit
    output logic line // receive pin level
);
    timeunit 1ns;
    timeprecision 1ps;
    // =====================================================
    // idle high on a standard line, low on infrared
    assign line = active ? bit_val : ~ir_mode;
endmodule
`default_nettype wire

// ---- bench/dual_uart_pin_signalling_tb.sv ----
// Purpose: self-checking bench for the two-channel pin logic
// Assumes: 40 MHz clk, fixed 3 cycle pin latency plus margin
// Notes: gp port never used as a free output while irq in use
`default_nettype none
module dual_uart_pin_signalling_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'h0, nrst = 1'h0, bus_sel_pin = 1'h1;
    logic [7:0] a_modem_control_reg = 8'h00, b_modem_control_reg = 8'h00;
    logic [7:0] a_feature_control_reg = 8'h00, b_feature_control_reg = 8'h00;
    logic [7:0] a_enhanced_feature_reg = 8'h00;
    logic [7:0] b_enhanced_feature_reg = 8'h00;
    logic [1:0] irq_req = 2'h0, tx_bit = 2'h0, tx_busy = 2'h0;
    logic [1:0] ir_pulse = 2'h0, tx_space = 2'h0, rx_avail = 2'h0;
    logic [1:0] src_act = 2'h0, src_bit = 2'h0;
    logic chan_a_serial_in, chan_b_serial_in;
    logic chan_a_clear_send_n = 1'h1, chan_b_clear_send_n = 1'h1;
    logic chan_a_irq_out, chan_a_irq_oe, chan_b_irq_out, chan_b_irq_oe;
    logic chan_a_gp_out_port, chan_b_gp_out_port;
    logic chan_a_tx_ready_n, chan_a_rx_ready_n;
    logic chan_b_tx_ready_n, chan_b_rx_ready_n;
    logic chan_a_serial_out, chan_b_serial_out;
    logic chan_a_request_send_n, chan_b_request_send_n;
    logic chan_a_terminal_ready_n, chan_b_terminal_ready_n;
    logic [1:0] rx_to_core, rx_to_ir, tx_allow;
    int err_count = 0, check_count = 0;
    // =====================================================
    // clock, design and far-side line models
    always #12.5 clk = ~clk;
    dual_uart_pin_signalling dut (.clk, .nrst, .bus_sel_pin,
        .a_modem_control_reg, .a_feature_control_reg, .a_enhanced_feature_reg,
        .b_modem_control_reg, .b_feature_control_reg, .b_enhanced_feature_reg,
        .irq_req, .tx_bit,
        .tx_busy, .ir_pulse, .tx_space, .rx_avail, .chan_a_serial_in,
        .chan_b_serial_in, .chan_a_clear_send_n, .chan_b_clear_send_n,
        .chan_a_irq_out, .chan_a_irq_oe, .chan_b_irq_out, .chan_b_irq_oe,
        .chan_a_gp_out_port, .chan_b_gp_out_port, .chan_a_tx_ready_n,
        .chan_a_rx_ready_n, .chan_b_tx_ready_n, .chan_b_rx_ready_n,
        .chan_a_serial_out, .chan_b_serial_out, .chan_a_request_send_n,
        .chan_b_request_send_n, .chan_a_terminal_ready_n,
        .chan_b_terminal_ready_n, .rx_to_core, .rx_to_ir, .tx_allow);
    line_src src_a (.ir_mode(a_modem_control_reg[6]), .active(src_act[0]),
        .bit_val(src_bit[0]), .line(chan_a_serial_in));
    line_src src_b (.ir_mode(b_modem_control_reg[6]), .active(src_act[1]),
        .bit_val(src_bit[1]), .line(chan_b_serial_in));
    // =====================================================
    // shared helpers
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp)
        begin
            err_count++;
            $display("mismatch at %0t got %0h exp %0h", $time, got, exp);
        end
    endtask
    // pins take three cycles through the two synchroniser flops and the channel register
    task automatic settle;
        repeat (4) @(negedge clk);
    endtask
    task automatic stop_test;
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // =====================================================
    // scenarios
    task automatic t_irq_strobe;
        bus_sel_pin = 1'h1;
        a_modem_control_reg = 8'h08;
        irq_req = 2'h1;
        settle();
        chk({chan_a_irq_oe, chan_a_irq_out, chan_a_gp_out_port,
            chan_b_irq_oe, chan_b_gp_out_port}, 8'h19);
        a_modem_control_reg = 8'h00;
        settle();
        chk({chan_a_irq_oe, chan_a_irq_out, chan_a_gp_out_port,
            chan_b_irq_oe, chan_b_gp_out_port}, 8'h0D);
    endtask
    task automatic t_rw_bus;
        bus_sel_pin = 1'h0;
        b_modem_control_reg = 8'h08;
        irq_req = 2'h3;
        settle();
        chk({chan_b_irq_out, chan_b_irq_oe, chan_b_gp_out_port,
            chan_a_irq_out}, 8'h04);
        bus_sel_pin = 1'h1;
        settle();
        chk({chan_b_irq_out, chan_b_irq_oe}, 8'h03);
        b_modem_control_reg = 8'h00;
        irq_req = 2'h0;
    endtask
    task automatic t_ready;
        tx_space = 2'h1;
        rx_avail = 2'h2;
        settle();
        chk({chan_a_tx_ready_n, chan_a_rx_ready_n, chan_b_tx_ready_n,
            chan_b_rx_ready_n}, 8'h06);
        tx_space = 2'h2;
        rx_avail = 2'h1;
        settle();
        chk({chan_a_tx_ready_n, chan_a_rx_ready_n, chan_b_tx_ready_n,
            chan_b_rx_ready_n}, 8'h09);
    endtask
    // channel a standard, channel b infrared at once
    task automatic t_serial;
        b_modem_control_reg = 8'h40;
        settle();
        chk({chan_a_serial_out, chan_b_serial_out}, 8'h02);
        tx_busy = 2'h3;
        tx_bit = 2'h2;
        ir_pulse = 2'h2;
        settle();
        chk({chan_a_serial_out, chan_b_serial_out}, 8'h01);
        tx_busy = 2'h0;
    endtask
    task automatic t_rx;
        b_feature_control_reg = 8'h04;
        src_act = 2'h1;
        src_bit = 2'h0;
        settle();
        chk({rx_to_core, rx_to_ir}, 8'h0A);
        src_act = 2'h0;
        b_feature_control_reg = 8'h00;
        settle();
        chk({rx_to_core, rx_to_ir}, 8'h0C);
    endtask
    // rts raised before auto cts is switched on
    task automatic t_flow;
        a_modem_control_reg = 8'h02;
        b_modem_control_reg = 8'h01;
        settle();
        chk({chan_a_request_send_n, chan_a_terminal_ready_n,
            chan_b_request_send_n, chan_b_terminal_ready_n}, 8'h06);
        a_enhanced_feature_reg = 8'h80;
        settle();
        chk({6'h00, tx_allow}, 8'h02);
        chan_a_clear_send_n = 1'h0;
        settle();
        chk({6'h00, tx_allow}, 8'h03);
    endtask
    // =====================================================
    // main sequence, checks idle levels while still in reset
    initial
    begin
        repeat (20) @(negedge clk);
        chk({chan_a_serial_out, chan_b_serial_out, chan_a_gp_out_port,
            chan_a_tx_ready_n}, 8'h0F);
        nrst = 1'h1;
        t_irq_strobe();
        t_rw_bus();
        t_ready();
        t_serial();
        t_rx();
        t_flow();
        stop_test();
    end
endmodule
`default_nettype wire
